// [wdlrc_ahb_slave.sv]
module wdlrc_ahb_slave
(
    input wire logic i_clk, // system clock
    input wire logic i_rst, // sync reset, high
    input wire logic i_hsel, // slave select
    input wire logic [7:0] i_haddr, // byte address, low bits
    input wire logic [1:0] i_htrans, // transfer type
    input wire logic i_hwrite, // write when high
    input wire logic i_hready, // bus ready
    output logic o_hreadyout, // slave ready
    output logic o_hresp, // always okay
    output logic o_wr_pulse, // write data phase
    output logic o_rd_pulse, // read wait cycle
    output wdlrc_pkg::wdlrc_addr_t o_addr // captured address
);
    logic next_hreadyout;
    logic next_wr_pulse;
    logic next_rd_pulse;
    wdlrc_pkg::wdlrc_addr_t next_addr;
    logic take;

    always_comb
    begin
        take = i_hsel && i_hready &&
            (i_htrans == 2'(wdlrc_pkg::WDLRC_HT_NONSEQ) ||
             i_htrans == 2'(wdlrc_pkg::WDLRC_HT_SEQ));
        next_addr = take ? i_haddr : o_addr;
        next_wr_pulse = take && i_hwrite;
        // reads take one wait state so a write just before is visible
        next_rd_pulse = take && !i_hwrite;
        next_hreadyout = !next_rd_pulse;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            o_wr_pulse <= 1'b0;
            o_rd_pulse <= 1'b0;
            o_addr <= 8'h00;
        end
        else
        begin
            o_hreadyout <= next_hreadyout;
            o_hresp <= 1'b0;
            o_wr_pulse <= next_wr_pulse;
            o_rd_pulse <= next_rd_pulse;
            o_addr <= next_addr;
        end
    end
endmodule : wdlrc_ahb_slave

// [wdlrc_counter.sv]
`include "wdlrc_defs.svh"
module wdlrc_counter
(
    input wire logic i_clk, // system clock
    input wire logic i_rst, // sync reset, high
    input wire logic i_load, // load pulse
    input wire logic [31:0] i_load_val, // value to load
    input wire logic i_dec, // count down this cycle
    output logic [31:0] o_count, // current count
    output logic o_zero // count is zero
);
    logic [31:0] next_count;

    always_comb
    begin
        if (i_load)
        begin
            next_count = i_load_val;
        end
        else if (i_dec && o_count != 32'h00000000)
        begin
            next_count = o_count - 32'h00000001;
        end
        else
        begin
            next_count = o_count;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_count <= `WDLRC_RELOAD_RST;
        end
        else
        begin
            o_count <= next_count;
        end
    end

    assign o_zero = (o_count == 32'h00000000);
endmodule : wdlrc_counter

// [wdlrc_cpu_model.sv]
module wdlrc_cpu_model
(
    input wire logic i_clk, // system clock
    input wire logic i_rst, // system reset taken
    input wire logic i_halt_go, // start a debugger halt
    input wire logic [7:0] i_halt_len, // halt length in cycles
    input wire logic i_sys_rst, // reset request from watchdog
    output logic o_dbg_halt, // core is halted
    output logic o_rst_seen // reset request was seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] left = 8'h00;
    initial o_rst_seen = 1'b0;
    always @(posedge i_clk)
    begin
        if (i_halt_go)
            left <= i_halt_len;
        else if (left != 8'h00)
            left <= left - 8'h01;
        // a request is latched until the system reset is carried out
        if (i_rst)
            o_rst_seen <= 1'b0;
        else if (i_sys_rst === 1'b1)
            o_rst_seen <= 1'b1;
    end
    assign o_dbg_halt = (left != 8'h00);
endmodule : wdlrc_cpu_model

// [wdlrc_defs.svh]
`ifndef WDLRC_DEFS_SVH
`define WDLRC_DEFS_SVH

`define WDLRC_OFS_RELOAD 8'h00
`define WDLRC_OFS_VALUE 8'h04
`define WDLRC_OFS_CTRL 8'h08
`define WDLRC_OFS_RIS 8'h0C
`define WDLRC_OFS_MASK 8'h10
`define WDLRC_OFS_MIS 8'h14
`define WDLRC_OFS_LOCK 8'h18
`define WDLRC_OFS_STATUS 8'h1C

`define WDLRC_CTRL_RUN 0
`define WDLRC_CTRL_RSTEN 1
`define WDLRC_CTRL_STALL 2
`define WDLRC_STAT_RUN 0
`define WDLRC_STAT_LOCK 1
`define WDLRC_INT_BIT 0

`define WDLRC_UNLOCK_KEY 32'h5A5AC3C3
`define WDLRC_RELOAD_RST 32'hFFFFFFFF

`endif

// [wdlrc_pkg.sv]
package wdlrc_pkg;
    typedef logic [31:0] wdlrc_word_t;
    typedef logic [7:0] wdlrc_addr_t;
    typedef enum logic [1:0]
    {
        WDLRC_HT_IDLE,
        WDLRC_HT_BUSY,
        WDLRC_HT_NONSEQ,
        WDLRC_HT_SEQ
    } wdlrc_htrans_e;
endpackage : wdlrc_pkg

// [wdlrc_tb.sv]
`include "wdlrc_defs.svh"
module wdlrc_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic go = 1'b0, rd_act = 1'b0, rdy, resp, irq, srst, halt, seen;
    logic [7:0] hlen = 8'h00;
    logic [31:0] exp_q[$];
    logic [31:0] d;
    int n_fail = 0, samples_checked = 0, cyc = 0, n;
    wdlrc_top i_wdlrc_top (.i_clk(clk), .i_rst(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hready(rdy), .i_hwdata(hwdata),
        .i_dbg_halt(halt), .o_hrdata(rdata), .o_hreadyout(rdy),
        .o_hresp(resp), .o_irq(irq), .o_sys_rst(srst));
    wdlrc_cpu_model i_wdlrc_cpu_model (.i_clk(clk), .i_rst(rst),
        .i_halt_go(go), .i_halt_len(hlen), .i_sys_rst(srst),
        .o_dbg_halt(halt), .o_rst_seen(seen));
    initial forever #20 clk = ~clk;
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            finish_test();
        end
    end
    // ready is taken at the rising edge, before that edge updates it
    task automatic bus_wait;
        @(posedge clk);
        while (rdy !== 1'b1)
            @(posedge clk);
    endtask : bus_wait
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= v;
        rd_act <= ~w;
        bus_wait();
        rd_act <= 1'b0;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ahb(1'b1, a, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask : rd
    always @(negedge clk)
    begin
        if (rd_act && rdy === 1'b1)
        begin
            samples_checked++;
            if (rdata !== exp_q[0] || resp !== 1'b0)
            begin
                n_fail++;
                $display("Error %0t: read %h, expected %h", $time, rdata,
                    exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    // mask picks {seen, srst, irq}; looked at once the edge has settled
    task automatic chk(input logic [2:0] m, input logic e);
        logic g;
        @(negedge clk);
        g = |({seen, srst, irq} & m);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %0t: output %b, expected %b", $time, g, e);
        end
        @(posedge clk);
    endtask : chk
    // counts falling edges until the output rises, within a window
    task automatic wait_sig(input logic s, input int lo, input int hi);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while ((s ? srst : irq) !== 1'b1 && n <= hi);
        samples_checked++;
        if (n < lo || n > hi)
        begin
            n_fail++;
            $display("Error %0t: output rose after %0d cycles", $time, n);
        end
        @(posedge clk);
    endtask : wait_sig
    task automatic do_reset;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset
    initial
    begin
        int nl;
        d = $urandom(19499);
        do_reset();
        rd(`WDLRC_OFS_STATUS, 32'h0);
        rd(`WDLRC_OFS_RELOAD, `WDLRC_RELOAD_RST);
        rd(`WDLRC_OFS_MASK, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h24, $urandom);
        chk(3'b011, 1'b0);
        d = $urandom;
        if (d == `WDLRC_UNLOCK_KEY)
            d = d ^ 32'h1;
        wr(`WDLRC_OFS_LOCK, d);
        rd(`WDLRC_OFS_LOCK, 32'h1);
        wr(`WDLRC_OFS_RELOAD, $urandom);
        wr(`WDLRC_OFS_CTRL, 32'h7);
        rd(`WDLRC_OFS_STATUS, 32'h2);
        rd(`WDLRC_OFS_RELOAD, `WDLRC_RELOAD_RST);
        wr(`WDLRC_OFS_LOCK, `WDLRC_UNLOCK_KEY);
        rd(`WDLRC_OFS_STATUS, 32'h0);
        wr(`WDLRC_OFS_RELOAD, d);
        rd(`WDLRC_OFS_RELOAD, d);
        nl = 20 + ($urandom % 30);
        wr(`WDLRC_OFS_CTRL, 32'h1);
        rd(`WDLRC_OFS_STATUS, 32'h1);
        rd(`WDLRC_OFS_MASK, 32'h1);
        wr(`WDLRC_OFS_RELOAD, 32'(nl));
        wait_sig(1'b0, nl, nl + 3);
        repeat (2 * nl + 8) @(posedge clk);
        chk(3'b110, 1'b0);
        rd(`WDLRC_OFS_RIS, 32'h1);
        wr(`WDLRC_OFS_MASK, 32'h0);
        chk(3'b001, 1'b0);
        rd(`WDLRC_OFS_MIS, 32'h0);
        wr(`WDLRC_OFS_MASK, 32'h1);
        chk(3'b001, 1'b1);
        // restart the count so no timeout falls inside the next two writes
        wr(`WDLRC_OFS_RELOAD, 32'(nl));
        wr(`WDLRC_OFS_CTRL, 32'h3);
        wr(`WDLRC_OFS_RIS, 32'h1);
        chk(3'b001, 1'b0);
        wait_sig(1'b0, nl - 1, nl + 3);
        wait_sig(1'b1, nl - 2, nl + 3);
        chk(3'b100, 1'b1);
        do_reset();
        rd(`WDLRC_OFS_STATUS, 32'h0);
        chk(3'b011, 1'b0);
        wr(`WDLRC_OFS_CTRL, 32'h5);
        wr(`WDLRC_OFS_RELOAD, 32'(nl));
        go <= 1'b1;
        hlen <= 8'h3C;
        @(posedge clk);
        go <= 1'b0;
        // one step is taken before the halt reaches the counter
        rd(`WDLRC_OFS_VALUE, 32'(nl - 1));
        wait_sig(1'b0, nl + 56, nl + 60);
        wr(`WDLRC_OFS_RIS, 32'h1);
        chk(3'b001, 1'b0);
        wr(`WDLRC_OFS_RELOAD, 32'h0);
        wait_sig(1'b0, 0, 2);
        rd(`WDLRC_OFS_RIS, 32'h1);
        finish_test();
    end
endmodule : wdlrc_tb

// [wdlrc_top.sv]
`include "wdlrc_defs.svh"
module wdlrc_top
(
    input wire logic i_clk, // system clock, 25 MHz
    input wire logic i_rst, // sync reset, high
    input wire logic i_hsel, // slave select
    input wire logic [31:0] i_haddr, // byte address
    input wire logic [1:0] i_htrans, // transfer type
    input wire logic i_hwrite, // write when high
    input wire logic [2:0] i_hsize, // transfer size, word only
    input wire logic i_hready, // bus ready
    input wire logic [31:0] i_hwdata, // write data
    input wire logic i_dbg_halt, // processor halted by debugger
    output logic [31:0] o_hrdata, // read data
    output logic o_hreadyout, // slave ready
    output logic o_hresp, // always okay
    output logic o_irq, // timeout interrupt, level
    output logic o_sys_rst // system reset request, level
);
    logic wr_pulse;
    logic rd_pulse;
    wdlrc_pkg::wdlrc_addr_t bus_addr;
    logic [31:0] count;
    logic cnt_zero;

    logic lock;
    logic run;
    logic rst_en;
    logic stall_en;
    logic [31:0] reload;
    logic ris;
    logic mask;
    logic next_lock;
    logic next_run;
    logic next_rst_en;
    logic next_stall_en;
    logic [31:0] next_reload;
    logic next_ris;
    logic next_mask;
    logic next_sys_rst;
    logic next_irq;
    logic [31:0] next_hrdata;

    logic cfg_ok;
    logic load_wr;
    logic ctrl_wr;
    logic mask_wr;
    logic clr_wr;
    logic lock_wr;
    logic stalled;
    logic tick;
    logic expire;
    logic cnt_load;
    logic [31:0] cnt_load_val;

    // the hsize input is accepted for completeness; only words are used
    logic unused_size;
    assign unused_size = ^i_hsize;

    function automatic logic hit(input wdlrc_pkg::wdlrc_addr_t a,
                                 input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic [31:0] bit_word(input logic b);
        bit_word = {31'h00000000, b};
    endfunction : bit_word

    wdlrc_ahb_slave u_slave
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr[7:0]),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hready(i_hready),
        .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp),
        .o_wr_pulse(wr_pulse),
        .o_rd_pulse(rd_pulse),
        .o_addr(bus_addr)
    );

    wdlrc_counter u_counter
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(cnt_load),
        .i_load_val(cnt_load_val),
        .i_dec(tick),
        .o_count(count),
        .o_zero(cnt_zero)
    );

    always_comb
    begin
        cfg_ok = wr_pulse && !lock;
        load_wr = cfg_ok && hit(bus_addr, `WDLRC_OFS_RELOAD);
        ctrl_wr = cfg_ok && hit(bus_addr, `WDLRC_OFS_CTRL);
        mask_wr = cfg_ok && hit(bus_addr, `WDLRC_OFS_MASK);
        // the interrupt clear stays open under lock so a handler can run
        clr_wr = wr_pulse && hit(bus_addr, `WDLRC_OFS_RIS) &&
            i_hwdata[`WDLRC_INT_BIT];
        lock_wr = wr_pulse && hit(bus_addr, `WDLRC_OFS_LOCK);
        stalled = stall_en && i_dbg_halt;
        tick = run && !stalled;
        expire = tick && cnt_zero && !load_wr;
    end

    always_comb
    begin
        next_lock = lock;
        if (lock_wr)
        begin
            // the key releases, any other value engages
            next_lock = (i_hwdata != `WDLRC_UNLOCK_KEY);
        end
        next_reload = load_wr ? i_hwdata : reload;
        next_run = run;
        next_rst_en = rst_en;
        next_stall_en = stall_en;
        next_mask = mask;
        if (ctrl_wr)
        begin
            // once started, only a system reset stops the counter
            next_run = run || i_hwdata[`WDLRC_CTRL_RUN];
            next_rst_en = i_hwdata[`WDLRC_CTRL_RSTEN];
            next_stall_en = i_hwdata[`WDLRC_CTRL_STALL];
        end
        if (mask_wr)
        begin
            next_mask = i_hwdata[`WDLRC_INT_BIT];
        end
        if (ctrl_wr && i_hwdata[`WDLRC_CTRL_RUN])
        begin
            next_mask = 1'b1;
        end
    end

    always_comb
    begin
        next_ris = ris;
        if (clr_wr)
        begin
            next_ris = 1'b0;
        end
        // a set in the clearing cycle wins
        if (expire || (load_wr && i_hwdata == 32'h00000000))
        begin
            next_ris = 1'b1;
        end
        // the reset request holds until the system reset clears it
        next_sys_rst = o_sys_rst || (expire && ris && rst_en);
        next_irq = next_ris && next_mask && next_run;
    end

    always_comb
    begin
        cnt_load = 1'b0;
        cnt_load_val = reload;
        if (load_wr && run)
        begin
            cnt_load = 1'b1;
            cnt_load_val = i_hwdata;
        end
        else if (expire || (clr_wr && run))
        begin
            cnt_load = 1'b1;
        end
        else if (ctrl_wr && !run && i_hwdata[`WDLRC_CTRL_RUN])
        begin
            cnt_load = 1'b1;
        end
    end

    always_comb
    begin
        next_hrdata = o_hrdata;
        if (rd_pulse)
        begin
            unique case (bus_addr)
                `WDLRC_OFS_RELOAD: next_hrdata = reload;
                `WDLRC_OFS_VALUE: next_hrdata = count;
                `WDLRC_OFS_CTRL: next_hrdata = {29'h00000000, stall_en,
                                                rst_en, run};
                `WDLRC_OFS_RIS: next_hrdata = bit_word(ris);
                `WDLRC_OFS_MASK: next_hrdata = bit_word(mask);
                `WDLRC_OFS_MIS: next_hrdata = bit_word(ris && mask && run);
                `WDLRC_OFS_LOCK: next_hrdata = bit_word(lock);
                `WDLRC_OFS_STATUS: next_hrdata = {30'h00000000, lock, run};
                default: next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            lock <= 1'b0;
            run <= 1'b0;
            rst_en <= 1'b0;
            stall_en <= 1'b0;
            reload <= `WDLRC_RELOAD_RST;
            ris <= 1'b0;
            mask <= 1'b0;
            o_sys_rst <= 1'b0;
            o_irq <= 1'b0;
            o_hrdata <= 32'h00000000;
        end
        else
        begin
            lock <= next_lock;
            run <= next_run;
            rst_en <= next_rst_en;
            stall_en <= next_stall_en;
            reload <= next_reload;
            ris <= next_ris;
            mask <= next_mask;
            o_sys_rst <= next_sys_rst;
            o_irq <= next_irq;
            o_hrdata <= next_hrdata;
        end
    end

    lock_blocks_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr_pulse && lock) |=> (reload == $past(reload) &&
        rst_en == $past(rst_en) && stall_en == $past(stall_en)))
        else $error("config changed while locked");

    unlock_key_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (lock_wr && i_hwdata == `WDLRC_UNLOCK_KEY) |=> !lock)
        else $error("unlock key did not release");

    lock_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (rd_pulse && hit(bus_addr, `WDLRC_OFS_LOCK)) |=>
        o_hrdata == bit_word($past(lock)))
        else $error("lock indication wrong");

    first_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
        expire |=> (count == $past(reload) && ris))
        else $error("timeout did not reload");

    live_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (load_wr && run) |=> count == $past(i_hwdata))
        else $error("live reload not applied");

    zero_irq_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (load_wr && i_hwdata == 32'h00000000) |=> ris)
        else $error("zero reload gave no interrupt");

    reset_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!rst_en && !o_sys_rst) |=> !o_sys_rst)
        else $error("reset issued while disabled");

    run_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (ctrl_wr && i_hwdata[`WDLRC_CTRL_RUN]) |=> run [*3])
        else $error("running indication not set");

    stall_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (stalled && !cnt_load) |=> $stable(count))
        else $error("counter moved while halted");

    resume_dec_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (tick && !cnt_zero && !cnt_load) |=> count == $past(count) - 1)
        else $error("counter did not step down");

    irq_enable_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (ctrl_wr && i_hwdata[`WDLRC_CTRL_RUN] && ris) |=> o_irq)
        else $error("enable did not enable interrupt");

    second_rst_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (expire && ris && rst_en) |=> o_sys_rst [*4])
        else $error("second timeout gave no reset");

    clr_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (clr_wr && run && !load_wr) |=> count == $past(reload))
        else $error("clear did not reload");

    reset_state_a: assert property (@(posedge i_clk)
        i_rst |=> (!lock && !run && !rst_en && !stall_en && !o_irq &&
        !o_sys_rst))
        else $error("bad state after reset");

    timeout_c: cover property (@(posedge i_clk) disable iff (i_rst)
        expire ##[1:20] clr_wr);
    sys_rst_c: cover property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_sys_rst));
    stall_c: cover property (@(posedge i_clk) disable iff (i_rst)
        run && stalled [*3]);
    locked_wr_c: cover property (@(posedge i_clk) disable iff (i_rst)
        wr_pulse && lock && hit(bus_addr, `WDLRC_OFS_RELOAD));
endmodule : wdlrc_top
